// ---- rtl/cmeh_core_mem_err.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cmeh_defines.vh"
module cmeh_core_mem_err (
  input  wire        clk,
  input  wire        reset,
  input  wire        csr_wr,
  input  wire [11:0] csr_addr,
  input  wire [31:0] csr_wdata,
  output reg  [31:0] csr_rdata,
  input  wire        ic_valid,
  input  wire [15:0] ic_data,
  input  wire [4:0]  ic_chk,
  input  wire        tag_valid,
  input  wire [15:0] tag_data,
  input  wire [4:0]  tag_chk,
  output reg         ic_set_invalidate,
  output reg         ic_refetch_flush,
  input  wire        ilm_fetch_valid,
  input  wire        ilm_fetch_oldest,
  input  wire        ilm_dma_valid,
  input  wire [31:0] ilm_rdata,
  input  wire [6:0]  ilm_rchk,
  output reg  [31:0] ilm_corr_data,
  output reg  [6:0]  ilm_corr_chk,
  output reg         ilm_wb,
  output reg         ilm_refetch,
  output reg         inst_access_fault,
  input  wire        dlm_ls_valid,
  input  wire        dlm_is_store,
  input  wire        dlm_nonspec,
  input  wire        dlm_retire,
  input  wire        dlm_dma_valid,
  input  wire [31:0] dlm_rdata,
  input  wire [6:0]  dlm_rchk,
  output reg  [31:0] dlm_corr_data,
  output reg  [6:0]  dlm_corr_chk,
  output reg         dlm_wb,
  output reg         load_access_fault,
  output reg         store_access_fault,
  output reg         dma_rvalid,
  output reg  [31:0] dma_rdata,
  output reg         dma_rerror,
  output reg         ic_corr_irq,
  output reg         ilm_corr_irq,
  output reg         dlm_corr_irq
);

  // How the block is organised
  //
  // Three protected stores feed this block:
  //   - icache data chunks and line tags, 16 bits each
  //   - the instruction local memory, 32-bit words
  //   - the data local memory, 32-bit words
  //
  // Icache side
  //   Detection only. Any hit on data or tag drops the whole set
  //   and asks for a refetch flush. No correction is attempted
  //   here, since the line has a clean copy in system memory.
  //   The parity or short-code choice is a build option; both
  //   data and tag use the same choice.
  //
  // Local memory side
  //   Full SECDED over 39-bit codewords. The decoder gives:
  //   - overall parity odd: single error, correctable
  //   - overall parity even, syndrome non-zero: double error
  //   - all zero: clean word
  //   Single errors are corrected here and handed back as a
  //   write-back word with fresh check bits. Double errors turn
  //   into access faults or a DMA error response.
  //
  // Counting side
  //   Three counter/threshold registers, one per store. Each
  //   counts at most one event per cycle; the interrupt is the
  //   counter bit selected by the threshold, so it is a level
  //   and never a latched flag.
  //
  // Timing
  //   Every output is registered: the answer to whatever is
  //   presented at one rising edge appears after that edge and
  //   stands for one cycle. Callers must sample it one cycle
  //   after the request, not in the launching time step.
  //
  // Limitations
  //   - No address of an error is kept, only counts.
  //   - A stuck-at bit in the instruction memory keeps producing
  //     the same single error on every fetch; the refetch loop
  //     relies on the write-back actually fixing the cell.
  //   - If instruction and data DMA reads coincide, only the
  //     data memory answer is returned; the bus above must not
  //     issue both in one cycle if it needs both.

  // SECDED check bits: six Hamming bits plus overall parity
  // Data bits fill the non-power-of-two positions 1..38 in order;
  // the six Hamming bits are the XOR of the positions of all ones.
  // The seventh bit makes the whole 39-bit codeword even, so the
  // all-zero word is a valid codeword and needs no special case.
  function [6:0] lm_chk;
    input [31:0] d;
    reg   [38:1] cw;
    reg   [5:0]  h;
    integer      i;
    integer      k;
    begin
      cw = 38'h0;
      k  = 0;
      for (i = 1; i <= 38; i = i + 1) begin
        if ((i & (i - 1)) != 0) begin
          cw[i] = d[k];
          k     = k + 1;
        end
      end
      h = 6'h00;
      for (i = 1; i <= 38; i = i + 1) begin
        if (cw[i]) h = h ^ i[5:0];
      end
      lm_chk = {^{d, h}, h};
    end
  endfunction

  // Corrects a single flipped data bit given its Hamming position
  // A syndrome that points at a check-bit position (a power of two)
  // or at nothing leaves the data untouched: the check bits are
  // regenerated anyway before they go back to the array.
  function [31:0] lm_fix;
    input [31:0] d;
    input [5:0]  pos;
    integer      i;
    integer      k;
    begin
      lm_fix = d;
      k      = 0;
      for (i = 1; i <= 38; i = i + 1) begin
        if ((i & (i - 1)) != 0) begin
          if (pos == i[5:0]) lm_fix[k] = ~d[k];
          k = k + 1;
        end
      end
    end
  endfunction

  // Short parity code for 16 bits: parity of four folds plus overall
  // Detection only; the mismatch of any bit is enough to act on,
  // so no syndrome decode is needed on the icache side.
  function [4:0] ic_code;
    input [15:0] d;
    begin
      ic_code = {^d, ^d[15:12], ^d[11:8], ^d[7:4], ^d[3:0]};
    end
  endfunction

  // Icache check: parity uses bit 0 only, ECC all five
  function ic_bad;
    input [15:0] d;
    input [4:0]  c;
    begin
      if (`CMEH_ICACHE_ECC)
        ic_bad = (ic_code(d) != c);
      else
        ic_bad = (^d) != c[0];
    end
  endfunction

  // Syndrome decode for both local memories
  // Bit 6 is the parity over the whole stored codeword, so a flip
  // of any bit, check bits included, shows as a single error.
  wire [6:0]  ilm_enc = lm_chk(ilm_rdata);  // Recomputed check bits
  wire [6:0]  dlm_enc = lm_chk(dlm_rdata);  // Recomputed check bits
  wire [6:0]  ilm_syn = {^{ilm_rdata, ilm_rchk},
                         ilm_enc[5:0] ^ ilm_rchk[5:0]};
  wire [6:0]  dlm_syn = {^{dlm_rdata, dlm_rchk},
                         dlm_enc[5:0] ^ dlm_rchk[5:0]};
  // Single error flips overall parity; double leaves it even
  // Three or more flips may alias to either; SECDED promises
  // nothing beyond two.
  wire        ilm_sb  = ilm_syn[6];
  wire        ilm_db  = (ilm_syn != 7'h00) && !ilm_syn[6];
  wire        dlm_sb  = dlm_syn[6];
  wire        dlm_db  = (dlm_syn != 7'h00) && !dlm_syn[6];
  wire [31:0] ilm_fx  = lm_fix(ilm_rdata, ilm_syn[5:0]);
  wire [31:0] dlm_fx  = lm_fix(dlm_rdata, dlm_syn[5:0]);

  // Error events per memory
  // Data and tag checks of one access fold into one event, which
  // keeps the icache counter at one step per cycle.
  wire ic_err  = (ic_valid && ic_bad(ic_data, ic_chk)) ||
                 (tag_valid && ic_bad(tag_data, tag_chk));
  wire ilm_use = ilm_fetch_valid || ilm_dma_valid;
  wire dlm_ret = dlm_ls_valid && dlm_retire && dlm_nonspec;
  // Data counts only on retire or DMA; DMA ignores power state
  // No sleep or debug-halt input exists on purpose: DMA reads must
  // be counted in every power state, so nothing may gate them.
  wire dlm_cnt = dlm_sb && (dlm_ret || dlm_dma_valid);
  wire ilm_cnt = ilm_sb && ilm_use;

  wire [2:0]  inc_v = {dlm_cnt, ilm_cnt, ic_err};
  wire [11:0] addr_v [0:2];
  assign addr_v[0] = `CMEH_CSR_IC;
  assign addr_v[1] = `CMEH_CSR_ILM;
  assign addr_v[2] = `CMEH_CSR_DLM;

  // Threshold clamp on software write
  // Values 27..31 would point past the 27-bit counter; they are
  // stored as 26, the highest legal bit.
  wire [4:0] wth = (csr_wdata[`CMEH_TH_HI:`CMEH_TH_LO] > `CMEH_TH_MAX) ?
                   `CMEH_TH_MAX : csr_wdata[`CMEH_TH_HI:`CMEH_TH_LO];

  wire [31:0] tally [0:2];
  wire [2:0]  irq_nxt;

  // Three counter/threshold registers, one per memory
  // Entry 0 serves the icache, 1 the instruction memory and 2 the
  // data memory. A software write in the same cycle as an error
  // wins; that one error is lost, which is the price of letting
  // firmware reset the count without a read-modify-write race.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tally
      reg  [4:0]  th_r;          // Threshold pointer
      reg  [26:0] cnt_r;         // Error count
      wire [26:0] cnt_nxt = cnt_r + 27'h1;
      // Counter and threshold update
      always @(posedge clk) begin
        if (reset) begin
          th_r  <= 5'h00;
          cnt_r <= 27'h0;
        end else if (csr_wr && csr_addr == addr_v[g]) begin
          // Software write replaces both fields and wins the cycle
          th_r  <= wth;
          cnt_r <= csr_wdata[`CMEH_CNT_HI:0];
        end else if (inc_v[g]) begin
          // One step per cycle however many hits
          cnt_r <= cnt_nxt; // Wraps silently
        end
      end
      assign tally[g] = {th_r, cnt_r};
      // Unlatched interrupt from the chosen bit, next value
      assign irq_nxt[g] = (csr_wr && csr_addr == addr_v[g]) ?
                          csr_wdata[wth] :
                          (inc_v[g] ? cnt_nxt[th_r] : cnt_r[th_r]);
    end
  endgenerate

  // Read mux: reads change nothing
  // Unmapped numbers read as zero; there is no error signalling
  // for them on this port.
  reg [31:0] rd_nxt;
  always @* begin
    if (csr_addr == `CMEH_CSR_IC)
      rd_nxt = tally[0];
    else if (csr_addr == `CMEH_CSR_ILM)
      rd_nxt = tally[1];
    else if (csr_addr == `CMEH_CSR_DLM)
      rd_nxt = tally[2];
    else
      rd_nxt = 32'h0000_0000;
  end

  // Registered outputs for recovery, faults and DMA answers
  // Corrected data and check bits are registered every cycle, even
  // when no write-back is asked for; only the strobes qualify them.
  // This avoids a mux on the wide paths at the cost of some toggling.
  always @(posedge clk) begin
    if (reset) begin
      csr_rdata          <= `CMEH_REG_RESET;
      ic_set_invalidate  <= 1'b0;
      ic_refetch_flush   <= 1'b0;
      ilm_corr_data      <= 32'h0000_0000;
      ilm_corr_chk       <= 7'h00;
      ilm_wb             <= 1'b0;
      ilm_refetch        <= 1'b0;
      inst_access_fault  <= 1'b0;
      dlm_corr_data      <= 32'h0000_0000;
      dlm_corr_chk       <= 7'h00;
      dlm_wb             <= 1'b0;
      load_access_fault  <= 1'b0;
      store_access_fault <= 1'b0;
      dma_rvalid         <= 1'b0;
      dma_rdata          <= 32'h0000_0000;
      dma_rerror         <= 1'b0;
      ic_corr_irq        <= 1'b0;
      ilm_corr_irq       <= 1'b0;
      dlm_corr_irq       <= 1'b0;
    end else begin
      csr_rdata <= rd_nxt;
      // Any icache error drops the set and refetches
      ic_set_invalidate <= ic_err;
      ic_refetch_flush  <= ic_err;
      // Corrected word and fresh check bits for write-back
      ilm_corr_data <= ilm_fx;
      ilm_corr_chk  <= lm_chk(ilm_fx);
      // Every corrected fetch or DMA read writes back
      ilm_wb        <= ilm_sb && ilm_use;
      // Refetch after write-back, used or not
      ilm_refetch   <= ilm_sb && ilm_fetch_valid;
      // Fault only when oldest; younger ones get flushed anyway
      inst_access_fault <= ilm_db && ilm_fetch_valid && ilm_fetch_oldest;
      dlm_corr_data <= dlm_fx;
      dlm_corr_chk  <= lm_chk(dlm_fx);
      // Speculative loads must not touch the array
      dlm_wb        <= dlm_sb && (dlm_ret || dlm_dma_valid);
      // Faults only on non-speculative accesses
      load_access_fault  <= dlm_db && dlm_ls_valid && dlm_nonspec &&
                            !dlm_is_store;
      store_access_fault <= dlm_db && dlm_ls_valid && dlm_nonspec &&
                            dlm_is_store;
      // DMA answer: corrected data or error
      dma_rvalid <= ilm_dma_valid || dlm_dma_valid;
      if (dlm_dma_valid) begin
        dma_rdata  <= dlm_fx;
        dma_rerror <= dlm_db;
      end else begin
        dma_rdata  <= ilm_fx;
        dma_rerror <= ilm_dma_valid && ilm_db;
      end
      // Interrupts track counter bits, no latch
      ic_corr_irq  <= irq_nxt[0];
      ilm_corr_irq <= irq_nxt[1];
      dlm_corr_irq <= irq_nxt[2];
    end
  end

endmodule
`default_nettype wire

// ---- rtl/cmeh_defines.vh ----
`ifndef CMEH_DEFINES_VH
`define CMEH_DEFINES_VH
`define CMEH_ICACHE_ECC  1'b1
`define CMEH_CSR_IC      12'h7F0
`define CMEH_CSR_ILM     12'h7F1
`define CMEH_CSR_DLM     12'h7F2
`define CMEH_TH_HI       31
`define CMEH_TH_LO       27
`define CMEH_CNT_HI      26
`define CMEH_TH_MAX      5'h1A
`define CMEH_REG_RESET   32'h0000_0000
`define CMEH_IC_DW       16
`define CMEH_IC_PW       5
`define CMEH_LM_DW       32
`define CMEH_LM_CW       7
`endif

// ---- verification/cmeh_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// One-word local memory standing behind the error block
module cmeh_mem_model (
  input  wire logic        clk,
  input  wire logic        sel,
  input  wire logic [38:0] flip,
  input  wire logic        wb,
  input  wire logic [31:0] wdata,
  input  wire logic [6:0]  wchk,
  output logic      [31:0] rdata,
  output logic      [6:0]  rchk
);
  // All-zero codeword is valid for any even code, so no encoder needed
  logic [38:0] word_r = 39'h0;
  // Takes corrected word and check bits back
  always @(posedge clk) begin
    if (wb) word_r <= {wchk, wdata};
  end
  // Deselected array shows inverted word, never a stale copy
  assign {rchk, rdata} = sel ? (word_r ^ flip) : ~word_r;
endmodule
`default_nettype wire

// ---- verification/cmeh_core_mem_err_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmeh_core_mem_err_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic ic_valid,
  input wire logic tag_valid,
  input wire logic ic_set_invalidate,
  input wire logic ic_refetch_flush,
  input wire logic ilm_fetch_valid,
  input wire logic ilm_fetch_oldest,
  input wire logic ilm_dma_valid,
  input wire logic ilm_wb,
  input wire logic ilm_refetch,
  input wire logic inst_access_fault,
  input wire logic dlm_ls_valid,
  input wire logic dlm_is_store,
  input wire logic dlm_nonspec,
  input wire logic dlm_dma_valid,
  input wire logic load_access_fault,
  input wire logic store_access_fault,
  input wire logic dma_rvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_dma_ans; (ilm_dma_valid || dlm_dma_valid) |=> dma_rvalid; endproperty
  a_dma_ans: assert property (p_dma_ans) else $error("dma answer missing");
  property p_dma_idle; !(ilm_dma_valid || dlm_dma_valid) |=> !dma_rvalid; endproperty
  a_dma_idle: assert property (p_dma_idle) else $error("dma answer unasked");
  property p_flush_inv; ic_refetch_flush |-> ic_set_invalidate; endproperty
  a_flush_inv: assert property (p_flush_inv) else $error("flush w/o invalidate");
  property p_inv_cause; !ic_valid && !tag_valid |=> !ic_set_invalidate; endproperty
  a_inv_cause: assert property (p_inv_cause) else $error("invalidate w/o check");
  property p_iaf; inst_access_fault |-> $past(ilm_fetch_valid && ilm_fetch_oldest); endproperty
  a_iaf: assert property (p_iaf) else $error("fault not on oldest fetch");
  property p_refetch; ilm_refetch |-> ilm_wb; endproperty
  a_refetch: assert property (p_refetch) else $error("refetch w/o writeback");
  property p_laf; load_access_fault |-> $past(dlm_ls_valid && dlm_nonspec && !dlm_is_store); endproperty
  a_laf: assert property (p_laf) else $error("bad load fault");
  property p_saf; store_access_fault |-> $past(dlm_ls_valid && dlm_nonspec && dlm_is_store); endproperty
  a_saf: assert property (p_saf) else $error("bad store fault");
endmodule
bind cmeh_core_mem_err cmeh_core_mem_err_checker u_chk (.*);
`default_nettype wire

// ---- verification/cmeh_core_mem_err_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmeh_core_mem_err_tb;
  logic        clk, reset, csr_wr;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, ilm_rdata, dlm_rdata, dma_rdata;
  logic [31:0] ilm_corr_data, dlm_corr_data;
  logic [15:0] ic_data, tag_data;
  logic [4:0]  ic_chk, tag_chk;
  logic [6:0]  ilm_rchk, dlm_rchk, ilm_corr_chk, dlm_corr_chk;
  logic [38:0] ilm_flip, dlm_flip; // Injected bit errors
  logic ic_valid, tag_valid, ic_set_invalidate, ic_refetch_flush, ilm_wb;
  logic ilm_fetch_valid, ilm_fetch_oldest, ilm_dma_valid, ilm_refetch;
  logic inst_access_fault, dlm_ls_valid, dlm_is_store, dlm_nonspec;
  logic dlm_retire, dlm_dma_valid, dlm_wb, load_access_fault;
  logic store_access_fault, dma_rvalid, dma_rerror;
  logic ic_corr_irq, ilm_corr_irq, dlm_corr_irq;
  int   n_fail, cmp_count, cycles;
  cmeh_core_mem_err u_dut (.*);
  cmeh_mem_model u_ilm (.clk(clk), .sel(ilm_fetch_valid | ilm_dma_valid),
    .flip(ilm_flip), .wb(ilm_wb), .wdata(ilm_corr_data),
    .wchk(ilm_corr_chk), .rdata(ilm_rdata), .rchk(ilm_rchk));
  cmeh_mem_model u_dlm (.clk(clk), .sel(dlm_ls_valid | dlm_dma_valid),
    .flip(dlm_flip), .wb(dlm_wb), .wdata(dlm_corr_data),
    .wchk(dlm_corr_chk), .rdata(dlm_rdata), .rchk(dlm_rchk));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Lets the request edge pass, then drops every strobe
  task step;
    @(negedge clk);
    {ic_valid, tag_valid, ilm_fetch_valid, ilm_dma_valid, csr_wr} = '0;
    {dlm_ls_valid, dlm_dma_valid, dlm_retire, ic_chk, tag_chk} = '0;
    {ilm_flip, dlm_flip} = '0;
  endtask
  task csr_w(input logic [11:0] a, input logic [31:0] d);
    csr_wr = 1'b1;
    csr_addr = a;
    csr_wdata = d;
    step;
  endtask
  task csr_r(input logic [11:0] a, input logic [31:0] e);
    csr_addr = a;
    step;
    chk(csr_rdata, e);
  endtask
  // Reset values, threshold clamp, unmapped address, wrap
  task t_regs;
    csr_r(12'h7F0, 32'h0);
    csr_r(12'h7F2, 32'h0);
    csr_w(12'h7F3, 32'h1);
    csr_r(12'h7F3, 32'h0);
    csr_w(12'h7F1, 32'hFFFF_FFFF);
    csr_r(12'h7F1, 32'hD7FF_FFFF);
    chk(ilm_corr_irq, 1'b1);
    ilm_dma_valid = 1'b1;
    ilm_flip = 39'h1;
    step;
    chk({dma_rvalid, dma_rerror, ilm_wb}, 3'b101);
    chk(dma_rdata, 32'h0);
    chk(ilm_corr_irq, 1'b0);
    csr_r(12'h7F1, 32'hD000_0000);
  endtask
  // Two errors in one cycle count once, then single ones count
  task t_icache;
    csr_w(12'h7F0, 32'h0800_0000);
    {ic_valid, tag_valid, ic_chk, tag_chk} = {2'b11, 5'h01, 5'h01};
    step;
    chk({ic_set_invalidate, ic_refetch_flush}, 2'b11);
    csr_r(12'h7F0, 32'h0800_0001);
    {tag_valid, tag_chk} = {1'b1, 5'h10};
    step;
    chk(ic_corr_irq, 1'b1);
    ic_valid = 1'b1;
    step;
    chk(ic_set_invalidate, 1'b0);
    csr_r(12'h7F0, 32'h0800_0002);
  endtask
  task t_ilm;
    csr_w(12'h7F1, 32'h0);
    {ilm_fetch_valid, ilm_fetch_oldest, ilm_flip} = {2'b10, 39'h4};
    step;
    chk({ilm_wb, ilm_refetch, inst_access_fault}, 3'b110);
    {ilm_fetch_valid, ilm_flip} = {1'b1, 39'h3};
    step;
    chk(inst_access_fault, 1'b0);
    {ilm_fetch_valid, ilm_fetch_oldest, ilm_flip} = {2'b11, 39'h3};
    step;
    chk({ilm_wb, inst_access_fault}, 2'b01);
    {ilm_dma_valid, ilm_flip} = {1'b1, 39'h6};
    step;
    chk({dma_rvalid, dma_rerror}, 2'b11);
    csr_r(12'h7F1, 32'h1);
  endtask
  task t_dlm;
    {dlm_ls_valid, dlm_nonspec, dlm_retire, dlm_flip} = {3'b111, 39'h8};
    step;
    chk({dlm_wb, dlm_corr_data}, 33'h1_0000_0000);
    chk(dlm_corr_chk, 7'h00);
    chk(dlm_corr_irq, 1'b1);
    {dlm_ls_valid, dlm_nonspec, dlm_flip} = {2'b10, 39'h8};
    step;
    chk(dlm_wb, 1'b0);
    {dlm_ls_valid, dlm_nonspec, dlm_flip} = {2'b11, 39'h5};
    step;
    chk({load_access_fault, store_access_fault}, 2'b10);
    {dlm_ls_valid, dlm_is_store, dlm_flip} = {2'b11, 39'h5};
    step;
    chk({load_access_fault, store_access_fault}, 2'b01);
    {dlm_dma_valid, dlm_flip} = {1'b1, 39'h10};
    step;
    chk({dma_rerror, dlm_wb, dma_rdata}, 34'h1_0000_0000);
    {dlm_dma_valid, dlm_flip} = {1'b1, 39'h30};
    step;
    chk(dma_rerror, 1'b1);
    chk(dlm_corr_irq, 1'b0);
    csr_r(12'h7F2, 32'h2);
  endtask
  task print_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard well beyond the fifty or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    {reset, ilm_fetch_oldest, dlm_is_store, dlm_nonspec} = 4'b1000;
    {csr_addr, csr_wdata, ic_data, tag_data} = '0;
    step;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    t_regs;
    t_icache;
    t_ilm;
    t_dlm;
    print_verdict;
  end
endmodule
`default_nettype wire
